// File: verilog/pinmux_defines.svh
/*
 * Constants of the strap-selected parallel-port pin mux: line count,
 * synchroniser depth and the drive values used in and after reset.
 * Assumes inclusion by bare name from the package and the mux module.
 */
`ifndef PINMUX_DEFINES_SVH
`define PINMUX_DEFINES_SVH

`define PMX_LINES        5
`define PMX_SYNC_DEPTH   3
`define PMX_STROBE_IDLE  5'h1F
`define PMX_ALL_OFF      5'h00
`define PMX_ALL_ON       5'h1F
`define PMX_STRAP_GPIO   1'h0
`define PMX_STRAP_EMC    1'h1

`endif

// File: verilog/pinmux_pkg.sv
/*
 * Types shared by the parallel-port pin mux: line drive bundle, the
 * general-purpose I/O request bundle, the memory-controller strobe
 * bundle, the selected function and the reset phase.
 * Assumes pinmux_defines.svh is on the include path.
 */
`include "pinmux_defines.svh"

package pinmux_pkg;

	// index 0 is line 5, index 4 is line 9
	typedef struct packed {
		logic [`PMX_LINES-1:0] out;
		logic [`PMX_LINES-1:0] oe;
	} line_drive_t;

	// index 0 is I/O bit 25, index 4 is I/O bit 29
	typedef struct packed {
		logic [`PMX_LINES-1:0] out;
		logic [`PMX_LINES-1:0] dir;
	} io_request_t;

	// active-low strobes, idle level 1
	typedef struct packed {
		logic ext_mem_byte_en_1;
		logic ext_mem_byte_en_0;
		logic ext_mem_chip_sel_3;
		logic ext_mem_chip_sel_2;
		logic ext_mem_chip_sel_1;
	} strobe_t;

	typedef enum logic {
		func_gpio,
		func_emc
	} func_t;

	typedef enum logic {
		phase_reset,
		phase_run
	} phase_t;

endpackage

// File: verilog/parallel_port_strap_pin_mux.sv
/*
 * Reset-time mux for five parallel-port lines. Each line is either a
 * general-purpose I/O bit or a memory-controller strobe, chosen by the
 * strap level seen while reset is held and frozen at reset release.
 * Assumes: strap and line inputs are asynchronous pins; the I/O and
 * memory-controller requests come from logic on sys_clk; resetn is held
 * low for at least four edges so the strap settles through its chain.
 */
`include "pinmux_defines.svh"

// Contract
// - Each of the five lines carries exactly one function, I/O bit or controller strobe, picked by the strap level during reset.
// - A low strap connects the lines to I/O bits 25 to 29 in line order.
// - A high strap connects the lines to chip selects 1, 2, 3 and byte enables 0, 1 in line order.
// - The function is fixed when reset rises and is kept from then on.
// - In I/O mode each bit's driver is off while reset is held and follows par_io_bit.dir from the first edge after release.
// - In controller mode each strobe line is undriven while reset is held.
// - After release in controller mode each strobe line drives 1 until the controller asserts it.
module parallel_port_strap_pin_mux
	import pinmux_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   resetn,
	input  wire logic                   pinmux_strap_in,
	input  wire logic [`PMX_LINES-1:0]  par_port_line_in,
	output      pinmux_pkg::line_drive_t par_port_line,
	input  wire pinmux_pkg::io_request_t par_io_bit,
	output      logic [`PMX_LINES-1:0]  par_io_bit_in,
	input  wire pinmux_pkg::strobe_t    ext_mem_ctrl,
	output      logic                   ext_mem_ctrl_sel,
	output      logic                   mux_locked
);
	import pinmux_pkg::*;

	// pin synchronisers, no reset so they track during reset
	logic [`PMX_SYNC_DEPTH-1:0] strap_sync;
	logic [`PMX_SYNC_DEPTH-1:0] next_strap_sync;
	logic [`PMX_LINES-1:0]      line_s1;
	logic [`PMX_LINES-1:0]      line_s2;
	logic [`PMX_LINES-1:0]      line_s3;
	logic [`PMX_LINES-1:0]      next_line_s1;
	logic [`PMX_LINES-1:0]      next_line_s2;
	logic [`PMX_LINES-1:0]      next_line_s3;

	always_comb
	begin
		next_strap_sync = {strap_sync[`PMX_SYNC_DEPTH-2:0], pinmux_strap_in};
		next_line_s1    = par_port_line_in;
		next_line_s2    = line_s1;
		next_line_s3    = line_s2;
	end

	always_ff @(posedge sys_clk)
	begin
		strap_sync <= next_strap_sync;
		line_s1    <= next_line_s1;
		line_s2    <= next_line_s2;
		line_s3    <= next_line_s3;
	end

	// strap candidate, followed only while reset is held
	logic strap_seen;
	logic next_strap_seen;
	logic strap_stable;

	assign strap_stable = strap_sync[1] == strap_sync[2];

	always_comb
	begin
		next_strap_seen = strap_seen;
		if (!resetn && strap_stable)
			next_strap_seen = strap_sync[2];
	end

	always_ff @(posedge sys_clk)
	begin
		strap_seen <= next_strap_seen;
	end

	// phase and frozen function
	phase_t phase;
	phase_t next_phase;
	func_t  func;
	func_t  next_func;

	always_comb
	begin
		next_phase = phase;
		next_func  = func;
		case (phase)
			phase_reset:
			begin
				next_phase = phase_run;
				next_func  = (strap_seen == `PMX_STRAP_EMC) ? func_emc : func_gpio;
			end
			phase_run:
			begin
				next_phase = phase_run;
				next_func  = func;
			end
			default:
			begin
				next_phase = phase_reset;
				next_func  = func_gpio;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			phase <= phase_reset;
			func  <= func_gpio;
		end
		else
		begin
			phase <= next_phase;
			func  <= next_func;
		end
	end

	// line drive, computed from the next phase so pins move with the lock
	line_drive_t next_line;
	logic [`PMX_LINES-1:0] next_io_in;
	logic [`PMX_LINES-1:0] io_filtered;

	always_comb
	begin
		next_line.out = `PMX_STROBE_IDLE;
		next_line.oe  = `PMX_ALL_OFF;
		if (resetn && next_phase == phase_run)
		begin
			if (next_func == func_emc)
			begin
				next_line.out = ext_mem_ctrl;
				next_line.oe  = `PMX_ALL_ON;
			end
			else
			begin
				next_line.out = par_io_bit.out;
				next_line.oe  = par_io_bit.dir;
			end
		end
	end

	// line input, a bit changes once its second and third stages agree
	always_comb
	begin
		for (int i = 0; i < `PMX_LINES; i++)
			io_filtered[i] = (line_s2[i] == line_s3[i]) ? line_s3[i] : par_io_bit_in[i];
		next_io_in = `PMX_ALL_OFF;
		if (resetn && next_phase == phase_run && next_func == func_gpio)
			next_io_in = io_filtered;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			par_port_line.out <= `PMX_STROBE_IDLE;
			par_port_line.oe  <= `PMX_ALL_OFF;
			par_io_bit_in     <= `PMX_ALL_OFF;
			ext_mem_ctrl_sel  <= 1'h0;
			mux_locked        <= 1'h0;
		end
		else
		begin
			par_port_line    <= next_line;
			par_io_bit_in    <= next_io_in;
			ext_mem_ctrl_sel <= next_func == func_emc;
			mux_locked       <= next_phase == phase_run;
		end
	end

	// checks
	AST_ONE_FUNC: assert property (@(posedge sys_clk) disable iff (!resetn)
		mux_locked && ext_mem_ctrl_sel |-> par_io_bit_in == `PMX_ALL_OFF)
		else $error("I/O input seen while lines carry controller strobes");

	AST_GPIO_MAP: assert property (@(posedge sys_clk) disable iff (!resetn)
		mux_locked && !ext_mem_ctrl_sel && $past(mux_locked)
		|-> par_port_line.oe == $past(par_io_bit.dir)
		&& par_port_line.out == $past(par_io_bit.out))
		else $error("I/O mode line drive does not follow I/O bits");

	AST_EMC_MAP: assert property (@(posedge sys_clk) disable iff (!resetn)
		mux_locked && ext_mem_ctrl_sel && $past(mux_locked)
		|-> par_port_line.out == $past(ext_mem_ctrl))
		else $error("controller mode line drive does not follow strobes");

	AST_LOCK_AT_RELEASE: assert property (@(posedge sys_clk)
		!resetn ##1 resetn |=> mux_locked
		&& ext_mem_ctrl_sel == $past(strap_seen))
		else $error("function not frozen from strap at reset release");

	AST_UNLOCKED_IN_RESET: assert property (@(posedge sys_clk)
		!resetn |=> !mux_locked && !ext_mem_ctrl_sel)
		else $error("function shown as frozen while reset held");

	AST_FUNC_HELD: assert property (@(posedge sys_clk) disable iff (!resetn)
		mux_locked |=> $stable(ext_mem_ctrl_sel) && mux_locked)
		else $error("selected function changed without reset");

	AST_GPIO_INPUT_FIRST: assert property (@(posedge sys_clk)
		!resetn ##1 !resetn |-> par_port_line.oe == `PMX_ALL_OFF && par_io_bit_in == `PMX_ALL_OFF)
		else $error("line driven or input passed while reset held");

	AST_EMC_TRISTATE: assert property (@(posedge sys_clk)
		!resetn |=> par_port_line.oe == `PMX_ALL_OFF)
		else $error("strobe line driven during reset");

	AST_EMC_DRIVE_ON: assert property (@(posedge sys_clk) disable iff (!resetn)
		mux_locked && ext_mem_ctrl_sel |-> par_port_line.oe == `PMX_ALL_ON)
		else $error("strobe line released while controller mode runs");

	AST_GPIO_IN_MAP: assert property (@(posedge sys_clk) disable iff (!resetn)
		mux_locked && !ext_mem_ctrl_sel && line_s2 == line_s3
		|=> par_io_bit_in == $past(line_s3))
		else $error("agreed line level not passed to I/O input");

	AST_EMC_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (!resetn)
		mux_locked && ext_mem_ctrl_sel && $past(ext_mem_ctrl) == `PMX_STROBE_IDLE
		|-> par_port_line.oe == `PMX_ALL_ON && par_port_line.out == `PMX_STROBE_IDLE)
		else $error("idle strobe line not driven high");

endmodule // parallel_port_strap_pin_mux

// File: bench/pinmux_board_model.sv
/* board side of the five parallel-port lines: resolves each wire level.
 * assumes the mux is the only on-chip driver; bench may drive the board. */
module pinmux_board_model
	import pinmux_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire pinmux_pkg::line_drive_t par_port_line,
	input  wire logic [4:0]              board_val,
	input  wire logic                    board_en,
	output      logic [4:0]              line_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] last = 5'h00;
	// released, undriven lines float to the inverse of their last driven level
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			line_level[i] = par_port_line.oe[i] ? par_port_line.out[i]
				: (board_en ? board_val[i] : ~last[i]);
	end
	always @(posedge sys_clk)
	begin
		for (int i = 0; i < 5; i++)
			if (par_port_line.oe[i] || board_en)
				last[i] <= line_level[i];
	end
endmodule // pinmux_board_model

// File: bench/tb_parallel_port_strap_pin_mux.sv
/* self-checking bench of the strap-selected pin mux, both modes.
 * assumes pinmux_pkg compiled first and the board model beside it. */
module tb_parallel_port_strap_pin_mux;
	timeunit 1ns;
	timeprecision 1ps;
	import pinmux_pkg::*;
	logic        sys_clk = 0;
	logic        resetn = 0;
	logic        pinmux_strap_in = 0;
	logic [4:0]  line_level;
	line_drive_t par_port_line;
	io_request_t par_io_bit = '0;
	logic [4:0]  par_io_bit_in;
	strobe_t     ext_mem_ctrl = strobe_t'(5'h1F);
	logic        sel;
	logic        locked;
	logic [4:0]  board_val = 0;
	logic        board_en = 0;
	int          mismatches = 0;
	int          n_checks = 0;
	always #2 sys_clk = ~sys_clk;
	parallel_port_strap_pin_mux i_dut (.sys_clk(sys_clk), .resetn(resetn),
		.pinmux_strap_in(pinmux_strap_in), .par_port_line_in(line_level),
		.par_port_line(par_port_line), .par_io_bit(par_io_bit),
		.par_io_bit_in(par_io_bit_in), .ext_mem_ctrl(ext_mem_ctrl),
		.ext_mem_ctrl_sel(sel), .mux_locked(locked));
	pinmux_board_model i_board (.sys_clk(sys_clk), .par_port_line(par_port_line),
		.board_val(board_val), .board_en(board_en), .line_level(line_level));
	task step;
		@(posedge sys_clk);
		#1;
	endtask
	task chk(input logic [4:0] got, input logic [4:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task do_reset(input logic s);
		pinmux_strap_in = s;
		resetn = 0;
		repeat (12) step();
		chk(par_port_line.oe, 5'h00);
		chk(par_port_line.out, 5'h1F);
		chk(par_io_bit_in, 5'h00);
		chk({4'h0, locked}, 5'h00);
		par_io_bit = '0;
		resetn = 1;
		step();
		chk({4'h0, sel}, {4'h0, s});
		chk({4'h0, locked}, 5'h01);
		// strap flips after release and must be ignored
		pinmux_strap_in = ~s;
	endtask
	task test_io;
		do_reset(1'b0);
		chk(par_port_line.oe, 5'h00);
		par_io_bit = '{out: 5'h0A, dir: 5'h1F};
		ext_mem_ctrl = strobe_t'(5'h00);
		step();
		chk(par_port_line.oe, 5'h1F);
		chk(par_port_line.out, 5'h0A);
		par_io_bit.dir = 5'h00;
		board_en = 1;
		board_val = 5'h15;
		repeat (5) step();
		chk(par_io_bit_in, 5'h15);
		chk({4'h0, sel}, 5'h00);
		board_en = 0;
		ext_mem_ctrl = strobe_t'(5'h1F);
	endtask
	task test_emc;
		logic [4:0] exp;
		do_reset(1'b1);
		chk(par_port_line.oe, 5'h1F);
		chk(par_port_line.out, 5'h1F);
		par_io_bit = '{out: 5'h00, dir: 5'h00};
		for (int i = 0; i < 5; i++)
		begin
			exp = ~(5'h01 << i);
			ext_mem_ctrl = strobe_t'(exp);
			step();
			chk(par_port_line.out, exp);
			chk(par_port_line.oe, 5'h1F);
			chk(par_io_bit_in, 5'h00);
		end
		ext_mem_ctrl = '{ext_mem_byte_en_1: 1'b0, default: 1'b1};
		step();
		chk(par_port_line.out, 5'h0F);
		ext_mem_ctrl = '{ext_mem_chip_sel_1: 1'b0, default: 1'b1};
		step();
		chk(par_port_line.out, 5'h1E);
		ext_mem_ctrl = strobe_t'(5'h1F);
		step();
		chk(par_port_line.out, 5'h1F);
		chk({4'h0, sel}, 5'h01);
	endtask
	initial
	begin
		#5000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		test_io();
		test_emc();
		test_io();
		give_verdict();
	end
endmodule // tb_parallel_port_strap_pin_mux
